// >>> src/rfp_top.sv
// fractional reference clock divider producing the tick enable
// assumes ref_clk is the peripheral clock; tick feeds the tick counter
`timescale 1ns/10ps
module rfp_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // register port
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // toward the clock_tick_counter
    output logic tick
);
    rfp_cfg_if cfg();
    logic [12:0] int_cnt_reg;
    logic [14:0] frac_cnt_reg;
    logic [14:0] frac_cnt_next;
    logic extend;
    logic term;

    rfp_regs u_regs (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .addr(addr),
        .wdata(wdata),
        .wr(wr),
        .rd(rd),
        .rdata(rdata),
        .cfg(cfg.regs)
    );

    rfp_extend u_ext (
        .frac_cnt(frac_cnt_next),
        .frac_val(cfg.frac_val),
        .extend(extend)
    );

    // =============================================
    // terminal count; period is int+1 clocks, or int+2 when lengthened
    assign term = (int_cnt_reg == 13'h0000);
    assign frac_cnt_next = frac_cnt_reg + 15'h0001;

    // integer counter; only moves on ref_clk, so a stopped clock stops time
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            int_cnt_reg <= 13'h0000;
        end else if (term) begin
            // wraps at max value; software keeps int below 8191
            int_cnt_reg <= extend ? cfg.int_val + 13'h0001 : cfg.int_val;
        end else begin
            int_cnt_reg <= int_cnt_reg - 13'h0001;
        end
    end

    // fraction counter steps once per output period
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            frac_cnt_reg <= 15'h0000;
        end else if (term) begin
            frac_cnt_reg <= frac_cnt_next;
        end
    end

    // one-cycle tick enable, registered
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tick <= 1'b0;
        end else begin
            tick <= term;
        end
    end

    // =============================================
    // checks
    a_tick_pulse_term: assert property (@(posedge ref_clk) disable iff (!resetn)
        term |=> tick) else $error("tick missed terminal count");
    a_reload_plain: assert property (@(posedge ref_clk) disable iff (!resetn)
        term && !extend |=> int_cnt_reg == $past(cfg.int_val))
        else $error("plain reload wrong");
    a_reload_long: assert property (@(posedge ref_clk) disable iff (!resetn)
        term && extend |=> int_cnt_reg == $past(cfg.int_val) + 13'h0001)
        else $error("lengthened reload wrong");
    a_count_down: assert property (@(posedge ref_clk) disable iff (!resetn)
        !term |=> int_cnt_reg == $past(int_cnt_reg) - 13'h0001)
        else $error("integer counter not counting down");
    a_frac_step: assert property (@(posedge ref_clk) disable iff (!resetn)
        term |=> frac_cnt_reg == $past(frac_cnt_reg) + 15'h0001)
        else $error("fraction counter step wrong");
    a_frac_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        !term |=> $stable(frac_cnt_reg)) else $error("fraction counter moved");
    a_half_weight: assert property (@(posedge ref_clk) disable iff (!resetn)
        term && cfg.frac_val[14] && frac_cnt_next[0] |-> extend)
        else $error("half weight missed");
    a_quarter_weight: assert property (@(posedge ref_clk) disable iff (!resetn)
        term && cfg.frac_val[13] && frac_cnt_next[1:0] == 2'h2 |-> extend)
        else $error("quarter weight missed");
    a_zero_frac: assert property (@(posedge ref_clk) disable iff (!resetn)
        cfg.frac_val == 15'h0000 |-> !extend)
        else $error("extension with zero fraction");
    a_period_len: assert property (@(posedge ref_clk) disable iff (!resetn)
        term && !extend && cfg.int_val == 13'h0001 |=> tick && !term ##1 term)
        else $error("period of two clocks wrong");
endmodule

// >>> src/rfp_pkg.sv
// constants shared by the fractional prescaler design files
// assumes one peripheral clock and a plain register port
//
// Behaviour
// - average 32.768 kHz ticks from pclk
// - exactly 32768 ticks per second
// - some periods one clock longer
// - 13-bit integer, 15-bit fraction counters
// - integer register bits 12:0, reset zero
// - fraction register bits 14:0, reset zero
// - integer counter counts down each clock
// - lengthened period reloads integer plus one
// - fraction bits pair with counter states
// - bit 14 lengthens when counter lsb set
// - bit 13 lengthens when low bits 10
// - spread evenly; zero fraction equal periods
// - no clock, no time advance
// - reprogramming applies directly, no compensation
package rfp_pkg;
    // =============================================
    // register map and layout
    localparam logic [31:0] RFP_INT_OFFSET = 32'he0024080;
    localparam logic [31:0] RFP_FRAC_OFFSET = 32'he0024084;
    localparam int RFP_INT_W = 13;
    localparam int RFP_FRAC_W = 15;
    localparam logic [12:0] RFP_INT_RESET = 13'h0000;
    localparam logic [14:0] RFP_FRAC_RESET = 15'h0000;
    // target tick rate in hertz
    localparam int RFP_TICK_HZ = 32768;
endpackage

// >>> src/rfp_cfg_if.sv
// divide settings passed from the register file to the divider core
// assumes both ends share ref_clk
`timescale 1ns/10ps
interface rfp_cfg_if;
    logic [12:0] int_val;
    logic [14:0] frac_val;
    modport regs (output int_val, output frac_val);
    modport core (input int_val, input frac_val);
endinterface

// >>> src/rfp_regs.sv
// register file for the two prescale registers
// assumes single-cycle strobes, read data one cycle later
`timescale 1ns/10ps
module rfp_regs (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // register port
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // settings toward the core
    rfp_cfg_if.regs cfg
);
    logic [12:0] prescale_integer_value_reg;
    logic [14:0] prescale_fraction_value_reg;

    // =============================================
    // writes: new ratios take effect at the next reload, no compensation
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            prescale_integer_value_reg <= rfp_pkg::RFP_INT_RESET;
            prescale_fraction_value_reg <= rfp_pkg::RFP_FRAC_RESET;
        end else if (wr) begin
            if (addr == rfp_pkg::RFP_INT_OFFSET) begin
                prescale_integer_value_reg <= wdata[12:0];
            end
            if (addr == rfp_pkg::RFP_FRAC_OFFSET) begin
                prescale_fraction_value_reg <= wdata[14:0];
            end
        end
    end

    // read data; reserved and unmapped read zero
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            if (addr == rfp_pkg::RFP_INT_OFFSET) begin
                rdata <= {19'h0, prescale_integer_value_reg};
            end else if (addr == rfp_pkg::RFP_FRAC_OFFSET) begin
                rdata <= {17'h0, prescale_fraction_value_reg};
            end else begin
                rdata <= 32'h0000_0000;
            end
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    assign cfg.int_val = prescale_integer_value_reg;
    assign cfg.frac_val = prescale_fraction_value_reg;
endmodule

// >>> src/rfp_extend.sv
// combinational decision whether the next period is lengthened
// assumes the fraction counter value after the coming terminal count
`timescale 1ns/10ps
module rfp_extend (
    // inputs
    input wire logic [14:0] frac_cnt,
    input wire logic [14:0] frac_val,
    // decision
    output logic extend
);
    logic [14:0] sel;

    // bit 14-k pairs with states whose lowest set bit is k, so bit
    // 14-k lengthens 2^(14-k) of every 2^15 periods, evenly spread
    genvar k;
    generate
        for (k = 0; k < 15; k++) begin : g_pair
            if (k == 0) begin : g_lsb
                assign sel[14] = frac_cnt[0];
            end else begin : g_up
                assign sel[14-k] = frac_cnt[k] && (frac_cnt[k-1:0] == '0);
            end
        end
    endgenerate

    // any set fraction bit whose state is present lengthens
    assign extend = |(sel & frac_val);
endmodule

// >>> verification/rfp_top_bench.sv
// self-checking bench for the fractional prescaler top
// assumes src/ files compiled first; bench drives every port itself
`timescale 1ns/10ps
module rfp_top_bench;
    // =========================================
    // ports, counters and the device
    logic ref_clk;
    logic resetn;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic tick;
    int error_cnt;
    int n_checks;
    int cyc;
    int n;
    int s;
    int lng;
    logic [31:0] d;
    rfp_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .tick(tick));
    // =========================================
    // clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // longest test is about 66k cycles, so this ceiling leaves margin
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 100000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    // =========================================
    // shared tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // strobes are one cycle; callers enter just after a rising edge
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // rdata is sampled before this edge's updates, i.e. the cycle after rd
    task automatic rd_reg(input logic [31:0] a, output logic [31:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(posedge ref_clk);
        v = rdata;
    endtask
    // clocks from the current tick to the next one, bounded
    task automatic period(output int p);
        p = 0;
        do begin
            @(posedge ref_clk);
            p++;
        end while (tick !== 1'b1 && p < 20000);
    endtask
    // new ratios only land at a reload, so skip two ticks before measuring
    task automatic set_div(input logic [12:0] iv, input logic [14:0] fv);
        wr_reg(rfp_pkg::RFP_INT_OFFSET, {19'h0, iv});
        wr_reg(rfp_pkg::RFP_FRAC_OFFSET, {17'h0, fv});
        period(n);
        period(n);
    endtask
    // =========================================
    // scenarios
    task automatic test_regs();
        rd_reg(rfp_pkg::RFP_INT_OFFSET, d);
        check("int reset", d, {19'h0, rfp_pkg::RFP_INT_RESET});
        rd_reg(rfp_pkg::RFP_FRAC_OFFSET, d);
        check("frac reset", d, {17'h0, rfp_pkg::RFP_FRAC_RESET});
        // reserved bits are never written with ones by software
        wr_reg(rfp_pkg::RFP_INT_OFFSET, 32'h00001fff);
        rd_reg(rfp_pkg::RFP_INT_OFFSET, d);
        check("int width", d, 32'h00001fff);
        wr_reg(rfp_pkg::RFP_FRAC_OFFSET, 32'h00007fff);
        rd_reg(rfp_pkg::RFP_FRAC_OFFSET, d);
        check("frac width", d, 32'h00007fff);
        wr_reg(32'he0024088, 32'h00000005);
        rd_reg(32'he0024088, d);
        check("unmapped", d, 32'h00000000);
    endtask
    task automatic test_equal();
        set_div(13'h0001, 15'h0000);
        repeat (4) begin
            period(n);
            check("equal period", n, 2);
        end
    endtask
    task automatic test_half();
        set_div(13'h0003, 15'h4000);
        period(n);
        period(s);
        check("half pair sum", n + s, 9);
        check("half spread", (n > s) ? n - s : s - n, 1);
    endtask
    task automatic test_quarter();
        set_div(13'h0002, 15'h2000);
        lng = 0;
        repeat (8) begin
            period(n);
            if (n == 4) lng++;
            else check("short period", n, 3);
        end
        check("quarter long count", lng, 2);
    endtask
    // 32768 periods visit every fraction state once, so the sum is exact
    task automatic test_second();
        set_div(13'h0001, 15'h0001);
        s = 0;
        repeat (32768) begin
            period(n);
            s += n;
        end
        check("second length", s, 65537);
    endtask
    // =========================================
    // main sequence
    initial begin
        resetn = 1'b0;
        addr = 32'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        test_regs();
        test_equal();
        test_half();
        test_quarter();
        test_second();
        report_and_stop();
    end
endmodule
